//--- inc/pio_regs.vh
// Register offsets, reset values and pin masks of the parallel port block.
`ifndef PIO_REGS_VH
`define PIO_REGS_VH
`define PIO_PORT_STRIDE 16'h0040
`define PIO_OFS_ANALOG 16'h0000
`define PIO_OFS_DIR 16'h0004
`define PIO_OFS_PINVAL 16'h0008
`define PIO_OFS_LATCH 16'h000c
`define PIO_OFS_ODRAIN 16'h0010
`define PIO_OFS_PULLUP 16'h0014
`define PIO_OFS_PULLDN 16'h0018
`define PIO_OFS_CNCTRL 16'h001c
`define PIO_OFS_CNEN0 16'h0020
`define PIO_OFS_CNSTAT 16'h0024
`define PIO_OFS_CNEN1 16'h0028
`define PIO_OFS_CNFLAG 16'h002c
`define PIO_RST_ANALOG 16'hffff
`define PIO_RST_DIR 16'hffff
`define PIO_RST_ZERO 16'h0000
`define PIO_CNCTRL_MASK 16'h8800
`define PIO_IMPL_A 16'h001f
`define PIO_IMPL_B 16'hffff
`define PIO_IMPL_C_FULL 16'h3fff
`define PIO_IMPL_C_MID 16'h003f
`define PIO_IMPL_D_FULL 16'h2502
`define PIO_ANA_A 16'h001f
`define PIO_ANA_B 16'h039f
`define PIO_ANA_C 16'h00cf
`define PIO_ANA_D 16'h2400
`define PIO_NUM_PORTS 4
`endif

//--- src/pio_sync.v
// Two-flop synchroniser for a bus of pin levels.
`timescale 1ns/100ps
`default_nettype none
module pio_sync #(
   parameter WIDTH = 16
) (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // Data
   input wire [WIDTH-1:0] async_in,
   output reg [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] stage1_reg;

   // The first stage is read only by the second stage to contain metastability.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage1_reg <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end else begin
         stage1_reg <= async_in;
         sync_out <= stage1_reg;
      end
   end
endmodule
`default_nettype wire

//--- src/pio_port.v
// Parallel I/O ports A to D with APB register access.
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "pio_regs.vh"
module pio_port #(
   parameter VARIANT = 2
) (
   // APB clock and reset
   input wire pclk,
   input wire presetn,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [15:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // Pins, 16 per port, port A in bits 15:0 up to port D in 63:48
   input wire [63:0] pin_in,
   output wire [63:0] pin_out,
   output wire [63:0] pin_oe,
   output wire [63:0] pull_up_en,
   output wire [63:0] pull_down_en,
   // Analog side: pins handed to analog peripherals
   output wire [63:0] analog_channel_pins
);
   // Byte offsets of the twelve registers inside one port window.
   localparam [15:0] OFS_ANALOG = `PIO_OFS_ANALOG;
   localparam [15:0] OFS_DIR = `PIO_OFS_DIR;
   localparam [15:0] OFS_PINVAL = `PIO_OFS_PINVAL;
   localparam [15:0] OFS_LATCH = `PIO_OFS_LATCH;
   localparam [15:0] OFS_ODRAIN = `PIO_OFS_ODRAIN;
   localparam [15:0] OFS_PULLUP = `PIO_OFS_PULLUP;
   localparam [15:0] OFS_PULLDN = `PIO_OFS_PULLDN;
   localparam [15:0] OFS_CNCTRL = `PIO_OFS_CNCTRL;
   localparam [15:0] OFS_CNEN0 = `PIO_OFS_CNEN0;
   localparam [15:0] OFS_CNSTAT = `PIO_OFS_CNSTAT;
   localparam [15:0] OFS_CNEN1 = `PIO_OFS_CNEN1;
   localparam [15:0] OFS_CNFLAG = `PIO_OFS_CNFLAG;
   // Register index inside one port window, taken from the word offsets.
   localparam [3:0] R_ANALOG = OFS_ANALOG[5:2];
   localparam [3:0] R_DIR = OFS_DIR[5:2];
   localparam [3:0] R_PINVAL = OFS_PINVAL[5:2];
   localparam [3:0] R_LATCH = OFS_LATCH[5:2];
   localparam [3:0] R_ODRAIN = OFS_ODRAIN[5:2];
   localparam [3:0] R_PULLUP = OFS_PULLUP[5:2];
   localparam [3:0] R_PULLDN = OFS_PULLDN[5:2];
   localparam [3:0] R_CNCTRL = OFS_CNCTRL[5:2];
   localparam [3:0] R_CNEN0 = OFS_CNEN0[5:2];
   localparam [3:0] R_CNSTAT = OFS_CNSTAT[5:2];
   localparam [3:0] R_CNEN1 = OFS_CNEN1[5:2];
   localparam [3:0] R_CNFLAG = OFS_CNFLAG[5:2];

   // Implemented-pin mask per port and variant; variant 2 is the largest package.
   function [15:0] impl_mask;
      input [1:0] port;
      begin
         case (port)
            2'd0: impl_mask = `PIO_IMPL_A;
            2'd1: impl_mask = `PIO_IMPL_B;
            2'd2: impl_mask = (VARIANT == 2) ? `PIO_IMPL_C_FULL :
                              (VARIANT == 1) ? `PIO_IMPL_C_MID : `PIO_RST_ZERO;
            2'd3: impl_mask = (VARIANT == 2) ? `PIO_IMPL_D_FULL : `PIO_RST_ZERO;
            default: impl_mask = `PIO_RST_ZERO;
         endcase
      end
   endfunction

   // Analog-capable pins, further limited to implemented pins.
   function [15:0] ana_mask;
      input [1:0] port;
      begin
         case (port)
            2'd0: ana_mask = `PIO_ANA_A & impl_mask(port);
            2'd1: ana_mask = `PIO_ANA_B & impl_mask(port);
            2'd2: ana_mask = `PIO_ANA_C & impl_mask(port);
            2'd3: ana_mask = `PIO_ANA_D & impl_mask(port);
            default: ana_mask = `PIO_RST_ZERO;
         endcase
      end
   endfunction

   // Byte-strobed merge of write data into a stored word, limited to the bits that exist.
   // Masking on every write keeps absent bits at zero without any per-bit special case.
   function [15:0] merge_word;
      input [15:0] old_word;
      input [15:0] new_word;
      input [15:0] byte_mask;
      input [15:0] keep_mask;
      begin
         merge_word = ((old_word & ~byte_mask) | (new_word & byte_mask)) & keep_mask;
      end
   endfunction

   // Address decode: port window and register index, word aligned.
   wire [1:0] port_sel = paddr[7:6];
   wire [3:0] reg_idx = paddr[5:2];
   wire addr_ok = (paddr[15:8] == 8'h00) && (paddr[1:0] == 2'b00) && (reg_idx <= R_CNFLAG);
   wire wr_en = psel && penable && pwrite && addr_ok;
   wire [15:0] wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

   // Zero-wait slave; unmapped or misaligned addresses answer with an error.
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addr_ok;

   wire [63:0] pin_sync;
   wire [63:0] pinval_all;
   wire [63:0] rd_vec;
   reg [15:0] rd_word;

   // Pin levels cross into the clock domain before any read logic.
   pio_sync #(
      .WIDTH(64)
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(pin_in),
      .sync_out(pin_sync)
   );

   genvar g;
   generate
      for (g = 0; g < `PIO_NUM_PORTS; g = g + 1) begin : g_port
         localparam [31:0] PNUM = g;
         localparam [1:0] PID = PNUM[1:0];
         localparam [15:0] IMPL = impl_mask(PID);
         localparam [15:0] ANA = ana_mask(PID);

         // Stored configuration of this port.
         reg [15:0] analog_reg;
         reg [15:0] dir_reg;
         reg [15:0] latch_reg;
         reg [15:0] odrain_reg;
         reg [15:0] pullup_reg;
         reg [15:0] pulldn_reg;
         reg [15:0] cnctrl_reg;
         reg [15:0] cnen0_reg;
         reg [15:0] cnen1_reg;
         reg [15:0] cnflag_reg;
         // Registered pin-side outputs, so no pin sees a glitch from the gating logic.
         reg [15:0] out_reg;
         reg [15:0] oe_reg;
         reg [15:0] pulldn_out_reg;
         // Next values of the stored registers.
         reg [15:0] analog_next;
         reg [15:0] dir_next;
         reg [15:0] latch_next;
         reg [15:0] odrain_next;
         reg [15:0] pullup_next;
         reg [15:0] pulldn_next;
         reg [15:0] cnctrl_next;
         reg [15:0] cnen0_next;
         reg [15:0] cnen1_next;
         reg [15:0] cnflag_next;
         reg [15:0] rd_part;
         wire hit = wr_en && (port_sel == PID);
         wire [15:0] wd = pwdata[15:0];

         // Twelve registers per port; a write to the change-status index is dropped,
         // since that register only reports and has no logic behind it here.
         always @* begin
            analog_next = analog_reg;
            dir_next = dir_reg;
            latch_next = latch_reg;
            odrain_next = odrain_reg;
            pullup_next = pullup_reg;
            pulldn_next = pulldn_reg;
            cnctrl_next = cnctrl_reg;
            cnen0_next = cnen0_reg;
            cnen1_next = cnen1_reg;
            cnflag_next = cnflag_reg;
            if (hit) begin
               case (reg_idx)
                  R_ANALOG: analog_next = merge_word(analog_reg, wd, wmask, ANA);
                  R_DIR: dir_next = merge_word(dir_reg, wd, wmask, IMPL);
                  R_PINVAL: latch_next = merge_word(latch_reg, wd, wmask, IMPL);
                  R_LATCH: latch_next = merge_word(latch_reg, wd, wmask, IMPL);
                  R_ODRAIN: odrain_next = merge_word(odrain_reg, wd, wmask, IMPL);
                  R_PULLUP: pullup_next = merge_word(pullup_reg, wd, wmask, IMPL);
                  R_PULLDN: pulldn_next = merge_word(pulldn_reg, wd, wmask, IMPL);
                  R_CNCTRL: cnctrl_next = merge_word(cnctrl_reg, wd, wmask, `PIO_CNCTRL_MASK);
                  R_CNEN0: cnen0_next = merge_word(cnen0_reg, wd, wmask, IMPL);
                  R_CNEN1: cnen1_next = merge_word(cnen1_reg, wd, wmask, IMPL);
                  R_CNFLAG: cnflag_next = merge_word(cnflag_reg, wd, wmask, IMPL);
                  default: cnflag_next = cnflag_reg;
               endcase
            end
         end

         // Pins to drive after this edge: direction zero drives the latch even with analog
         // select set, so analog peripherals can convert the driven level.
         wire [15:0] drive_next = ~dir_next & IMPL;

         // State and pin-side outputs update together; the outputs are built from the
         // next values, so a register write reaches the pins with no extra cycle.
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               analog_reg <= `PIO_RST_ANALOG & ANA;
               dir_reg <= `PIO_RST_DIR & IMPL;
               latch_reg <= `PIO_RST_ZERO;
               odrain_reg <= `PIO_RST_ZERO;
               pullup_reg <= `PIO_RST_ZERO;
               pulldn_reg <= `PIO_RST_ZERO;
               cnctrl_reg <= `PIO_RST_ZERO;
               cnen0_reg <= `PIO_RST_ZERO;
               cnen1_reg <= `PIO_RST_ZERO;
               cnflag_reg <= `PIO_RST_ZERO;
               out_reg <= `PIO_RST_ZERO;
               oe_reg <= `PIO_RST_ZERO;
               pulldn_out_reg <= `PIO_RST_ZERO;
            end else begin
               analog_reg <= analog_next;
               dir_reg <= dir_next;
               latch_reg <= latch_next;
               odrain_reg <= odrain_next;
               pullup_reg <= pullup_next;
               pulldn_reg <= pulldn_next;
               cnctrl_reg <= cnctrl_next;
               cnen0_reg <= cnen0_next;
               cnen1_reg <= cnen1_next;
               cnflag_reg <= cnflag_next;
               // Open-drain pins only pull low; a latch one releases the pin.
               out_reg <= latch_next & ~odrain_next;
               oe_reg <= drive_next & ~(odrain_next & latch_next);
               // Pull-up takes precedence, so the pull-down is masked where both are on.
               pulldn_out_reg <= pulldn_next & ~pullup_next;
            end
         end

         assign pin_out[16*g +: 16] = out_reg;
         assign pin_oe[16*g +: 16] = oe_reg;
         assign pull_up_en[16*g +: 16] = pullup_reg;
         assign pull_down_en[16*g +: 16] = pulldn_out_reg;
         assign analog_channel_pins[16*g +: 16] = analog_reg;
         // Digital input is disabled on analog pins, which therefore read low.
         assign pinval_all[16*g +: 16] = pin_sync[16*g +: 16] & IMPL & ~analog_reg;

         // Read data of this port, muxed by register index.
         always @* begin
            case (reg_idx)
               R_ANALOG: rd_part = analog_reg;
               R_DIR: rd_part = dir_reg;
               R_PINVAL: rd_part = pinval_all[16*g +: 16];
               R_LATCH: rd_part = latch_reg;
               R_ODRAIN: rd_part = odrain_reg;
               R_PULLUP: rd_part = pullup_reg;
               R_PULLDN: rd_part = pulldn_reg;
               R_CNCTRL: rd_part = cnctrl_reg;
               R_CNEN0: rd_part = cnen0_reg;
               R_CNEN1: rd_part = cnen1_reg;
               R_CNFLAG: rd_part = cnflag_reg;
               default: rd_part = `PIO_RST_ZERO; // Change status has no logic here.
            endcase
         end
         assign rd_vec[16*g +: 16] = rd_part;
      end
   endgenerate

   // Select the addressed port's word.
   always @* begin
      case (port_sel)
         2'd0: rd_word = rd_vec[15:0];
         2'd1: rd_word = rd_vec[31:16];
         2'd2: rd_word = rd_vec[47:32];
         default: rd_word = rd_vec[63:48];
      endcase
   end

   // Read data is registered in the setup cycle, so it is valid in the access
   // phase; the pin path then lags the pins by the synchroniser depth.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= addr_ok ? {16'h0000, rd_word} : 32'h00000000;
      end
   end
endmodule
`default_nettype wire

//--- test/pio_port_sva.sv
// Concurrent checks on the pin and bus ports of the parallel port block.
`timescale 1ns/100ps
`default_nettype none
module pio_port_sva #(
   parameter VARIANT = 2
) (
   // Clock, reset and bus
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   // Pins
   input wire logic [63:0] pin_in,
   input wire logic [63:0] pin_out,
   input wire logic [63:0] pin_oe,
   input wire logic [63:0] pull_up_en,
   input wire logic [63:0] pull_down_en,
   input wire logic [63:0] analog_channel_pins
);
   // Analog bits exist only on implemented, analog-capable pins.
   localparam logic [63:0] IMPL = {VARIANT == 2 ? 32'h2502_3fff : (VARIANT == 1 ? 32'h0000_003f : 32'h0), 32'hffff_001f};
   localparam logic [63:0] ANA = IMPL & 64'h2400_00cf_039f_001f;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_rst_in; $rose(presetn) |-> pin_oe == 64'h0; endproperty
   a_rst_in: assert property (p_rst_in) else $error("pins driven after reset");
   property p_rst_ana; $rose(presetn) |-> analog_channel_pins == ANA; endproperty
   a_rst_ana: assert property (p_rst_ana) else $error("analog select reset wrong");
   property p_unimpl; (pin_oe & ~IMPL) == 64'h0 && (analog_channel_pins & ~ANA) == 64'h0; endproperty
   a_unimpl: assert property (p_unimpl) else $error("absent bit active");
   property p_pull; (pull_up_en & pull_down_en) == 64'h0; endproperty
   a_pull: assert property (p_pull) else $error("pull-down beside pull-up");
   property p_refuse; psel && penable && (paddr[15:8] != 8'h0 || paddr[1:0] != 2'h0 || paddr[5:2] > 4'hb) |-> pslverr;
   endproperty
   a_refuse: assert property (p_refuse) else $error("bad address accepted");
   property p_upper; psel && penable && !pwrite |-> prdata[31:16] == 16'h0; endproperty
   a_upper: assert property (p_upper) else $error("read upper half set");
   property p_dir; psel && penable && pwrite && paddr == 16'h0004 |=> pin_oe[4:0] == ~$past(pwdata[4:0]); endproperty
   a_dir: assert property (p_dir) else $error("direction write not seen");
   property p_drive; psel && penable && pwrite && paddr == 16'h000c ##1 pin_oe[4:0] == 5'h1f
      |-> pin_out[4:0] == $past(pwdata[4:0]); endproperty
   a_drive: assert property (p_drive) else $error("latch not driven");
   property p_pin; $stable(pin_in[4:0]) [*3] ##0 (psel && !penable && !pwrite && paddr == 16'h0008)
      |=> prdata[4:0] == ($past(pin_in[4:0]) & ~$past(analog_channel_pins[4:0])); endproperty
   a_pin: assert property (p_pin) else $error("pin value read wrong");
endmodule
bind pio_port pio_port_sva #(.VARIANT(VARIANT)) u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
   .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
   .analog_channel_pins(analog_channel_pins));
`default_nettype wire

//--- test/pio_pin_model.sv
// Behavioural model of the circuitry attached to the port pins.
`timescale 1ns/100ps
`default_nettype none
module pio_pin_model (
   // Clock and port side
   input wire logic pclk,
   input wire logic [63:0] pin_out,
   input wire logic [63:0] pin_oe,
   input wire logic [63:0] pull_up_en,
   input wire logic [63:0] pull_down_en,
   // Outside drivers and resolved levels
   input wire logic [63:0] ext_en,
   input wire logic [63:0] ext_val,
   output logic [63:0] pin_level
);
   logic [63:0] float_reg = 64'h0;
   // A floating line toggles every cycle so a stale level never passes for a match.
   always @(posedge pclk) begin
      float_reg <= ~float_reg;
   end
   // The port wins, then outside drivers, then pull-up over pull-down.
   assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) |
      (~pin_oe & ~ext_en & (pull_up_en | (~pull_down_en & float_reg)));
endmodule
`default_nettype wire

//--- test/pio_port_tb_top.sv
// Self-checking bench for the parallel port block.
`timescale 1ns/100ps
`default_nettype none
module pio_port_tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
   logic [15:0] paddr = 16'h0;
   logic [3:0] pstrb = 4'h3;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [63:0] pin_in, pin_out, pin_oe, pull_up_en, pull_down_en, ana, ext_en = 64'h0, ext_val = 64'h0;
   int err_count = 0;
   int num_checks = 0;
   // Clock at 40 MHz.
   always #12.5 pclk = ~pclk;
   pio_port #(.VARIANT(2)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
      .analog_channel_pins(ana));
   pio_pin_model u_pins (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pull_up_en),
      .pull_down_en(pull_down_en), .ext_en(ext_en), .ext_val(ext_val), .pin_level(pin_in));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One transfer; the request stands until pready is seen high at a rising edge.
   task automatic apb(input logic wr, input logic [15:0] addr, input logic [31:0] data);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= data;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdchk(input string what, input logic [15:0] addr, input logic [31:0] exp);
      apb(1'b0, addr, 32'h0);
      check(what, rd, exp);
   endtask
   task automatic test_reset;
      check("oe", pin_oe[63:32] | pin_oe[31:0], 32'h0);
      rdchk("dir_a", 16'h0004, 32'h001f);
      rdchk("dir_d", 16'h00c4, 32'h2502);
      rdchk("ana_b", 16'h0040, 32'h039f);
      rdchk("ana_c", 16'h0080, 32'h00cf);
      apb(1'b1, 16'h00cc, 32'hffff);
      rdchk("latch_d", 16'h00cc, 32'h2502);
   endtask
   task automatic test_drive;
      apb(1'b1, 16'h0000, 32'h0);
      apb(1'b1, 16'h0004, 32'h0);
      apb(1'b1, 16'h000c, 32'h0015);
      repeat (3) @(posedge pclk);
      check("oe_a", {27'h0, pin_oe[4:0]}, 32'h1f);
      check("out_a", {27'h0, pin_out[4:0]}, 32'h15);
      rdchk("latch_a", 16'h000c, 32'h15);
      rdchk("pin_a", 16'h0008, 32'h15);
      apb(1'b1, 16'h0008, 32'h000a);
      rdchk("latch_w", 16'h000c, 32'h0a);
      apb(1'b1, 16'h0000, 32'h001f);
      repeat (3) @(posedge pclk);
      rdchk("pin_ana", 16'h0008, 32'h0);
      check("oe_ana", {27'h0, pin_oe[4:0]}, 32'h1f);
      check("ana_a", {27'h0, ana[4:0]}, 32'h1f);
   endtask
   task automatic test_input;
      ext_en[31:16] <= 16'hffff;
      ext_val[31:16] <= 16'ha5c3;
      apb(1'b1, 16'h0040, 32'h0300);
      repeat (3) @(posedge pclk);
      rdchk("pin_b", 16'h0048, 32'ha4c3);
      // Low byte strobe only: the upper latch byte must keep its old value.
      pstrb <= 4'h1;
      apb(1'b1, 16'h004c, 32'h1234);
      pstrb <= 4'h3;
      rdchk("latch_b", 16'h004c, 32'h0034);
   endtask
   task automatic test_pull_drain;
      apb(1'b1, 16'h0054, 32'h00ff);
      apb(1'b1, 16'h0058, 32'h0f0f);
      @(posedge pclk);
      check("pd_b", {16'h0, pull_down_en[31:16]}, 32'h0f00);
      check("pu_b", {16'h0, pull_up_en[31:16]}, 32'h00ff);
      apb(1'b1, 16'h0000, 32'h0);
      apb(1'b1, 16'h0014, 32'h001f);
      apb(1'b1, 16'h0010, 32'h001f);
      apb(1'b1, 16'h000c, 32'h0005);
      repeat (3) @(posedge pclk);
      check("od_oe", {27'h0, pin_oe[4:0]}, 32'h1a);
      rdchk("od_pin", 16'h0008, 32'h05);
   endtask
   task automatic test_refuse;
      apb(1'b0, 16'h0030, 32'h0);
      check("err", {31'h0, err}, 32'h1);
      check("err_rd", rd, 32'h0);
      apb(1'b1, 16'h0102, 32'hffff);
      check("err_wr", {31'h0, err}, 32'h1);
   endtask
   // A second reset in mid-run must bring every pin back to input, and the analog-capable pins of port A to analog mode.
   task automatic test_reset_again;
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      check("oe_rst", pin_oe[63:32] | pin_oe[31:0], 32'h0);
      rdchk("dir_a_rst", 16'h0004, 32'h001f);
      rdchk("ana_a_rst", 16'h0000, 32'h001f);
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // Main sequence after eight cycles of reset.
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      test_reset();
      test_drive();
      test_input();
      test_pull_drain();
      test_refuse();
      test_reset_again();
      complete_run();
   end
   // Watchdog: the scenarios need about 113 cycles, this allows four thousand.
   initial begin
      #100000;
      err_count++;
      complete_run();
   end
endmodule
`default_nettype wire
